// ---- bench/smp_far_end.sv ----
/*
   smp_far_end: far side of the link in clock mode 0: a slave to a
   master port, or a master clocked from the link clock.
   Assumes the bench resolves each pin from every enable.
*/
module smp_far_end (
   input wire logic link_clk_i,
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic miso_i,
   output logic sck_o,
   output logic mosi_o,
   output logic miso_o,
   output logic nss_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic mst = 1'b0;
   logic fr = 1'b0;
   logic [7:0] stx = 8'h00;
   logic [7:0] rx = 8'h00;
   // idle clock low, select released
   initial
   begin
      sck_o = 1'b0;
      nss_o = 1'b1;
   end
   // lone slave always drives; idle data line shows the inverse
   assign miso_o = stx[7];
   assign mosi_o = fr ? stx[7] : ~stx[7];
   // change on falling edge, sample on rising edge
   always @(negedge sck_i)
      stx <= {stx[6:0], 1'b0};
   always @(posedge sck_i)
      rx <= {rx[6:0], mst ? miso_i : mosi_i};
   // byte to return as slave
   task automatic load(input logic [7:0] b);
      mst = 1'b0;
      stx = b;
   endtask : load
   // select level outside frames
   task automatic hold(input logic v);
      nss_o = v;
   endtask : hold
   // one byte as master; clock stands still outside the frame
   task automatic frame(input logic [7:0] b, input logic sel);
      mst = 1'b1;
      stx = b;
      @(posedge link_clk_i);
      fr = 1'b1;
      nss_o = ~sel;
      repeat (2) @(posedge link_clk_i);
      repeat (16)
      begin
         repeat (2) @(posedge link_clk_i);
         sck_o = ~sck_o;
      end
      @(posedge link_clk_i);
      nss_o = 1'b1;
      fr = 1'b0;
   endtask : frame
endmodule : smp_far_end

// ---- bench/smp_port_monitor.sv ----
/*
   smp_port_monitor: port checks for the serial port unit.
   Assumes it is bound onto smp_port; one clock domain.
*/
module smp_port_monitor (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic cfg_wr_i,
   input wire logic [1:0] select_mode_field_i,
   input wire logic data_wr_i,
   input wire logic nss_i,
   input wire logic port_enable_bit_o,
   input wire logic master_enable_bit_o,
   input wire logic [7:0] data_o,
   input wire logic transfer_complete_flag_o,
   input wire logic write_collision_flag_o,
   input wire logic mode_fault_flag_o,
   input wire logic receive_overrun_flag_o,
   input wire logic tx_buffer_empty_o,
   input wire logic busy_o,
   input wire logic miso_oe_n_o,
   input wire logic nss_o,
   input wire logic nss_oe_n_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] mode_q;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // copy of the loaded mode; outputs may lag it a cycle
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
      if (!rst_n_i)
         mode_q <= smp_pkg::RST_SELECT_MODE;
      else if (cfg_wr_i)
         mode_q <= select_mode_field_i;
   a_off_float: assert property (
      $past(!port_enable_bit_o) && !port_enable_bit_o |-> miso_oe_n_o)
      else $error("slave out driven while off");
   a_unsel_float: assert property (
      (port_enable_bit_o && !master_enable_bit_o && mode_q == 2'h1
      && nss_i) [*3] |-> miso_oe_n_o) else $error("unselected drives");
   a_sel_level: assert property (
      $stable(mode_q) && mode_q[1] && port_enable_bit_o
      |-> !nss_oe_n_o && nss_o == mode_q[0])
      else $error("select out wrong");
   a_fault_set: assert property (
      (master_enable_bit_o && port_enable_bit_o && mode_q == 2'h1
      && !nss_i) [*2] |-> ##[0:4] mode_fault_flag_o) else $error("no fault");
   a_write_collision_flag_set: assert property (
      data_wr_i && !tx_buffer_empty_o |=> write_collision_flag_o)
      else $error("no collision flag");
   a_write_fill: assert property (
      data_wr_i && tx_buffer_empty_o |=> !tx_buffer_empty_o)
      else $error("write not taken");
   a_done_end: assert property (
      $fell(busy_o) && master_enable_bit_o
      |-> ##[0:6] transfer_complete_flag_o) else $error("no done flag");
   a_ovrn_keep: assert property (
      $rose(receive_overrun_flag_o) |-> $stable(data_o))
      else $error("overrun byte replaced data");
endmodule : smp_port_monitor

bind smp_port smp_port_monitor u_smp_port_monitor (.*);

// ---- bench/smp_port_tb_top.sv ----
/*
   smp_port_tb_top: self-checking bench for the serial port unit.
   Assumes smp_port, smp_far_end and the bound monitor.
*/
module smp_port_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_i = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n_i = 1'b0;
   logic cfg_wr_i = 1'b0;
   logic port_enable_bit_i = 1'b0;
   logic master_enable_bit_i = 1'b0;
   logic [1:0] select_mode_field_i = 2'h1;
   logic data_wr_i = 1'b0;
   logic data_rd_i = 1'b0;
   logic [7:0] data_i = 8'h00;
   logic [3:0] flag_clr_i = 4'h0;
   logic cpol = 1'b0;
   logic cpha = 1'b0;
   logic [7:0] clk_div = 8'h03;
   logic [7:0] data_o;
   logic port_enable_bit_o, master_enable_bit_o, busy_o, shift_empty_o;
   logic transfer_complete_flag_o, write_collision_flag_o;
   logic mode_fault_flag_o, receive_overrun_flag_o, rx_buffer_full_o;
   logic tx_buffer_empty_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o;
   logic miso_o, miso_oe_n_o, nss_o, nss_oe_n_o, nss_pin_mapped_o;
   logic m_sck, m_mosi, m_miso, m_nss;
   int error_cnt = 0;
   int n_checks = 0;
   // each pin: the design while its enable is low, else the far end
   wire sck_i = !sck_oe_n_o ? sck_o : m_sck;
   wire mosi_i = !mosi_oe_n_o ? mosi_o : m_mosi;
   wire miso_i = !miso_oe_n_o ? miso_o : m_miso;
   wire nss_i = !nss_oe_n_o ? nss_o : m_nss;
   // system and link clocks, unrelated periods
   always #12.5 ref_clk_i = ~ref_clk_i;
   always #32 link_clk = ~link_clk;
   smp_port u_smp_port (.ref_clk_i, .rst_n_i, .cfg_wr_i,
      .port_enable_bit_i, .master_enable_bit_i, .select_mode_field_i,
      .clock_polarity_bit_i(cpol), .clock_phase_bit_i(cpha),
      .clk_div_i(clk_div), .port_enable_bit_o, .master_enable_bit_o,
      .data_wr_i, .data_i, .data_rd_i, .data_o, .flag_clr_i,
      .transfer_complete_flag_o, .write_collision_flag_o,
      .mode_fault_flag_o, .receive_overrun_flag_o, .tx_buffer_empty_o,
      .rx_buffer_full_o, .shift_empty_o, .busy_o, .sck_i, .sck_o,
      .sck_oe_n_o, .mosi_i, .mosi_o, .mosi_oe_n_o, .miso_i, .miso_o,
      .miso_oe_n_o, .nss_i, .nss_o, .nss_oe_n_o, .nss_pin_mapped_o);
   smp_far_end u_smp_far_end (.link_clk_i(link_clk), .sck_i, .mosi_i,
      .miso_i, .sck_o(m_sck), .mosi_o(m_mosi), .miso_o(m_miso),
      .nss_o(m_nss));
   // compare helpers
   task automatic chk(input string nm, input logic [7:0] e, g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic chk1(input string nm, input logic e, g);
      chk(nm, {7'h00, e}, {7'h00, g});
   endtask : chk1
   // drivers, all entered and left at a falling edge
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : cyc
   task automatic cfg(input logic pe, me, input logic [1:0] md);
      port_enable_bit_i = pe;
      master_enable_bit_i = me;
      select_mode_field_i = md;
      cfg_wr_i = 1'b1;
      cyc(1);
      cfg_wr_i = 1'b0;
      cyc(1);
   endtask : cfg
   task automatic wr(input logic [7:0] b, input int n);
      data_i = b;
      data_wr_i = 1'b1;
      cyc(n);
      data_wr_i = 1'b0;
      cyc(1);
   endtask : wr
   task automatic clr(input logic rd);
      flag_clr_i = 4'hF;
      data_rd_i = rd;
      cyc(1);
      flag_clr_i = 4'h0;
      data_rd_i = 1'b0;
   endtask : clr
   // bounded wait for the done flag
   task automatic wait_done();
      for (int i = 0; i < 300 && transfer_complete_flag_o !== 1'b1; i++)
         cyc(1);
      chk1("done", 1'b1, transfer_complete_flag_o);
   endtask : wait_done
   // select pin as an output follows the low mode bit
   task automatic t_selout();
      chk1("mapped", 1'b1, nss_pin_mapped_o);
      chk1("miso off", 1'b1, miso_oe_n_o);
      for (int i = 2; i < 4; i++)
      begin
         cfg(1'b1, 1'b1, i[1:0]);
         chk1("nss out", i[0], nss_i);
         chk1("nss oe_n", 1'b0, nss_oe_n_o);
      end
      // idle clock level follows polarity, changed only while off
      cfg(1'b0, 1'b0, 2'h1);
      cpol = 1'b1;
      cfg(1'b1, 1'b1, 2'h0);
      chk1("idle clock", 1'b1, sck_o);
      cpol = 1'b0;
      cfg(1'b0, 1'b0, 2'h1);
      $display("end select out");
   endtask : t_selout
   // master byte; a second write lands on a full buffer
   task automatic t_master();
      u_smp_far_end.load(8'h3C);
      clk_div = 8'h05;
      cfg(1'b1, 1'b1, 2'h0);
      chk1("mapped", 1'b0, nss_pin_mapped_o);
      wr(8'hA5, 2);
      chk1("collision", 1'b1, write_collision_flag_o);
      wait_done();
      chk("master rx", 8'h3C, data_o);
      chk("far rx", 8'hA5, u_smp_far_end.rx);
      cyc(80);
      chk1("no resend", 1'b0, busy_o);
      $display("end master");
   endtask : t_master
   // low select while master in mode 01
   task automatic t_fault();
      clr(1'b1);
      cfg(1'b1, 1'b1, 2'h1);
      u_smp_far_end.hold(1'b0);
      cyc(6);
      chk1("fault", 1'b1, mode_fault_flag_o);
      chk1("enable", 1'b0, port_enable_bit_o);
      chk1("master", 1'b0, master_enable_bit_o);
      u_smp_far_end.hold(1'b1);
      cyc(4);
      $display("end fault");
   endtask : t_fault
   // four-wire slave: byte, unselected clocks, then overrun
   task automatic t_slave4();
      clr(1'b1);
      cfg(1'b1, 1'b0, 2'h1);
      wr(8'h96, 1);
      u_smp_far_end.frame(8'h5A, 1'b1);
      wait_done();
      chk("slave rx", 8'h5A, data_o);
      chk1("rx full", 1'b1, rx_buffer_full_o);
      chk("far rx", 8'h96, u_smp_far_end.rx);
      chk1("shift empty", 1'b1, shift_empty_o);
      clr(1'b0);
      u_smp_far_end.frame(8'h11, 1'b0);
      cyc(10);
      chk1("ignored", 1'b0, transfer_complete_flag_o);
      chk1("miso off", 1'b1, miso_oe_n_o);
      u_smp_far_end.frame(8'h22, 1'b1);
      cyc(10);
      chk1("overrun", 1'b1, receive_overrun_flag_o);
      chk("kept", 8'h5A, data_o);
      $display("end slave four wire");
   endtask : t_slave4
   // three-wire slave; a write after the first edge must wait
   task automatic t_slave3();
      clr(1'b1);
      cfg(1'b0, 1'b0, 2'h0);
      cfg(1'b1, 1'b0, 2'h0);
      wr(8'hC3, 1);
      fork
         u_smp_far_end.frame(8'h69, 1'b0);
         begin
            cyc(20);
            wr(8'hE7, 1);
         end
      join
      wait_done();
      cyc(3);
      chk("slave rx", 8'h69, data_o);
      chk("far rx", 8'hC3, u_smp_far_end.rx);
      chk1("miso on", 1'b0, miso_oe_n_o);
      chk1("tx moved", 1'b1, tx_buffer_empty_o);
      chk1("no clock", 1'b1, sck_oe_n_o);
      $display("end slave three wire");
   endtask : t_slave3
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   // main sequence after two reset cycles
   initial
   begin
      cyc(2);
      rst_n_i = 1'b1;
      cyc(3);
      t_selout();
      t_master();
      t_fault();
      t_slave4();
      t_slave3();
      print_verdict();
   end
   // run needs under a thousand cycles; cut a hang well past that
   initial
   begin
      #400000;
      error_cnt++;
      print_verdict();
   end
endmodule : smp_port_tb_top

// ---- rtl/smp_pkg.sv ----
/*
   smp_pkg: constants shared by the serial port unit (select modes,
   reset values, flag positions, bit and edge counts).
   Assumes a 40 MHz system clock; the serial clock rate comes from a
   divider value supplied at the ports.
*/
package smp_pkg;

   // select_mode_field encodings
   localparam logic [1:0] SEL_THREE_WIRE = 2'h0;
   localparam logic [1:0] SEL_MULTI = 2'h1;

   // values after reset
   localparam logic [1:0] RST_SELECT_MODE = 2'h1;
   localparam logic RST_PORT_ENABLE = 1'h0;
   localparam logic RST_MASTER_ENABLE = 1'h0;
   localparam logic RST_CLOCK_POLARITY = 1'h0;
   localparam logic RST_CLOCK_PHASE = 1'h0;
   localparam logic [7:0] RST_BYTE = 8'h00;

   // flag positions on flag_clr_i
   localparam int FLAG_DONE = 0;
   localparam int FLAG_WRITE_COLLISION_FLAG = 1;
   localparam int FLAG_MODE_FAULT_FLAG = 2;
   localparam int FLAG_OVRN = 3;
   localparam int FLAG_COUNT = 4;

   // counts
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [3:0] EDGE_LAST = 4'hF;
   localparam int DIV_WIDTH = 8;

   // least lead of select before the first serial clock edge
   localparam real SYS_CLK_MHZ = 40.0;
   localparam int SEL_LEAD_SYS_CYCLES = 2;

   // master sequencer states
   typedef enum logic [1:0] {
      SMP_M_IDLE = 2'h1,
      SMP_M_RUN = 2'h2
   } smp_mstate_e;

endpackage : smp_pkg

// ---- rtl/smp_port.sv ----
/*
   smp_port: byte-wide serial port unit acting as master or slave.
   Holds control bits, transmit buffer, shift register, receive buffer
   and flags in the system clock domain; the slave's bit capture runs
   on the incoming serial clock.
   Assumes: pins are split into input, output and active-low enable;
   the external master keeps the slave clock at most 1/10 of ref_clk_i.
*/
// What this block does
// - every byte shifts most significant bit first, both directions
// - master drives master-out from the shift register top bit
// - slave-out floats when disabled or an unselected four-wire slave
// - three-wire slave drives slave-out continuously from shift data
// - four-wire slave ignores serial clock while select is high
// - mode 00: three-wire, select unused, slave always selected
// - mode 01: select input; low selects slave, low stops master
// - mode 1x: select is an output equal to the low mode bit
// - select pin mapped in every mode except three-wire
// - master write goes to buffer, starts transfer if shifter empty
// - master transfer end sets the transfer complete flag
// - master copies received byte to receive buffer, read returns it
// - multi-master low select clears enables and sets mode fault
// - enabled non-master acts as slave, never starts a transfer
// - slave counts clock edges; after 8 bits flag and copy byte
// - slave write loads shifter now if empty, else after transfer
// - slave shift data frozen from first clock edge to transfer end
// - four-wire slave active only while selected; counter cleared
// - three-wire slave counter reset only when slave mode drops (port enable off or master enable on)
// - write while buffer still full is dropped, collision flag set
// - slave byte dropped and overrun set when receive buffer full
// - polarity sets idle clock level, phase picks the data edge
module smp_port #(
   parameter int DIV_W = smp_pkg::DIV_WIDTH
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // control and status
   input wire logic cfg_wr_i,
   input wire logic port_enable_bit_i,
   input wire logic master_enable_bit_i,
   input wire logic [1:0] select_mode_field_i,
   input wire logic clock_polarity_bit_i,
   input wire logic clock_phase_bit_i,
   input wire logic [DIV_W-1:0] clk_div_i,
   output logic port_enable_bit_o,
   output logic master_enable_bit_o,
   input wire logic data_wr_i,
   input wire logic [7:0] data_i,
   input wire logic data_rd_i,
   output logic [7:0] data_o,
   input wire logic [smp_pkg::FLAG_COUNT-1:0] flag_clr_i,
   output logic transfer_complete_flag_o,
   output logic write_collision_flag_o,
   output logic mode_fault_flag_o,
   output logic receive_overrun_flag_o,
   output logic tx_buffer_empty_o,
   output logic rx_buffer_full_o,
   output logic shift_empty_o,
   output logic busy_o,
   // serial pins
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_n_o,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_n_o,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_n_o,
   input wire logic nss_i,
   output logic nss_o,
   output logic nss_oe_n_o,
   output logic nss_pin_mapped_o
);

   typedef struct packed {
      logic miso_s1;
      logic miso_s2;
      logic nss_s1;
      logic nss_s2;
      logic busy_s1;
      logic busy_s2;
      logic done_s1;
      logic done_s2;
      logic done_s3;
      logic port_en;
      logic master_en;
      logic [1:0] mode;
      logic cpol;
      logic cpha;
      logic [7:0] tx_hold;
      logic tx_full;
      logic [7:0] shreg;
      logic sh_empty;
      logic [7:0] rx_buf;
      logic rx_full;
      logic [smp_pkg::FLAG_COUNT-1:0] flags;
      smp_pkg::smp_mstate_e mstate;
      logic [DIV_W-1:0] div_cnt;
      logic [3:0] edge_cnt;
      logic sck_lvl;
      logic rx_bit;
   } smp_sys_s;

   typedef struct packed {
      logic [2:0] cnt;
      logic [7:0] rx;
      logic active;
   } smp_link_s;

   // finished byte and its toggle live apart from the bit counter:
   // a select or enable drop clears the counter, and must not flip
   // the toggle, or the system side would see a false completion
   typedef struct packed {
      logic [7:0] rx_byte;
      logic done_tgl;
   } smp_done_s;

   logic [1:0] rst_ff;
   logic rst_n;
   smp_sys_s s;
   smp_sys_s next_s;
   smp_link_s l;
   smp_link_s next_l;
   smp_done_s d;
   smp_done_s next_d;
   logic [2:0] out_pos;
   logic sck_eff;
   logic link_rst_n;
   logic slave_on;
   logic slave_sel;

   // reset release through two flops
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rst_ff <= 2'h0;
      else
         rst_ff <= {rst_ff[0], 1'h1};
   end
   assign rst_n = rst_ff[1];

   // enabled but not master means slave
   assign slave_on = s.port_en & ~s.master_en;
   // slave selection per mode, synced select for the pin driver
   assign slave_sel = (s.mode == smp_pkg::SEL_THREE_WIRE) |
      ((s.mode == smp_pkg::SEL_MULTI) & ~s.nss_s2);

   // link logic held in reset when not an active, selected slave;
   // select high clears the counter, so its fall starts at bit zero
   assign link_rst_n = rst_n & slave_on &
      ~((s.mode == smp_pkg::SEL_MULTI) & nss_i);

   // one edge sense for all four clock settings
   assign sck_eff = sck_i ^ (s.cpol ^ s.cpha);

   // link side: sample edge shifts receive data in, msb first
   always_comb
   begin
      next_l = l;
      next_d = d;
      next_l.rx = {l.rx[6:0], mosi_i};
      next_l.cnt = l.cnt + 3'h1;
      next_l.active = (l.cnt != smp_pkg::BIT_LAST);
      if (l.cnt == smp_pkg::BIT_LAST)
      begin
         next_d.rx_byte = {l.rx[6:0], mosi_i};
         next_d.done_tgl = ~d.done_tgl;
      end
   end

   // byte hand-over to the system side, cleared only with the block
   always_ff @(posedge sck_eff or negedge rst_n)
   begin
      if (!rst_n)
         d <= '0;
      else
         d <= next_d;
   end

   always_ff @(posedge sck_eff or negedge link_rst_n)
   begin
      if (!link_rst_n)
         l <= '0;
      else
         l <= next_l;
   end

   // shift edge picks the next outgoing bit; no copy of the data is
   // made, the system side keeps shreg still while a byte is moving
   always_ff @(negedge sck_eff or negedge link_rst_n)
   begin
      if (!link_rst_n)
         out_pos <= 3'h0;
      else
         out_pos <= l.cnt;
   end

   // system side
   always_comb
   begin
      logic done_evt;
      logic [7:0] fin;
      logic tick;
      done_evt = 1'h0;
      fin = 8'h00;
      tick = 1'h0;
      next_s = s;

      // pin and domain crossings, two flops each, a third on the done toggle for its edge
      next_s.miso_s1 = miso_i;
      next_s.miso_s2 = s.miso_s1;
      next_s.nss_s1 = nss_i;
      next_s.nss_s2 = s.nss_s1;
      next_s.busy_s1 = l.active;
      next_s.busy_s2 = s.busy_s1;
      next_s.done_s1 = d.done_tgl;
      next_s.done_s2 = s.done_s1;
      next_s.done_s3 = s.done_s2;
      done_evt = s.done_s2 ^ s.done_s3;

      // flag clears first, so a set in the same cycle wins
      next_s.flags = s.flags & ~flag_clr_i;
      if (data_rd_i)
         next_s.rx_full = 1'h0;

      if (cfg_wr_i)
      begin
         next_s.port_en = port_enable_bit_i;
         next_s.master_en = master_enable_bit_i;
         next_s.mode = select_mode_field_i;
         next_s.cpol = clock_polarity_bit_i;
         next_s.cpha = clock_phase_bit_i;
      end

      // master sequencer
      unique case (s.mstate)
         smp_pkg::SMP_M_IDLE:
         begin
            next_s.sck_lvl = s.cpol;
            next_s.div_cnt = '0;
            next_s.edge_cnt = 4'h0;
            if (s.port_en & s.master_en & s.tx_full)
            begin
               next_s.shreg = s.tx_hold;
               next_s.tx_full = 1'h0;
               next_s.mstate = smp_pkg::SMP_M_RUN;
            end
         end
         smp_pkg::SMP_M_RUN:
         begin
            tick = (s.div_cnt == clk_div_i);
            next_s.div_cnt = tick ? '0 : s.div_cnt + 1'h1;
            if (tick)
            begin
               next_s.sck_lvl = ~s.sck_lvl;
               next_s.edge_cnt = s.edge_cnt + 4'h1;
               // even edges sample in phase 0, odd edges in phase 1
               if (s.edge_cnt[0] == s.cpha)
                  next_s.rx_bit = s.miso_s2;
               else if (s.edge_cnt != 4'h0)
                  next_s.shreg = {s.shreg[6:0], s.rx_bit};
               if (s.edge_cnt == smp_pkg::EDGE_LAST)
               begin
                  fin = {s.shreg[6:0], s.cpha ? s.miso_s2 : s.rx_bit};
                  next_s.shreg = fin;
                  next_s.rx_buf = fin;
                  next_s.rx_full = 1'h1;
                  next_s.flags[smp_pkg::FLAG_DONE] = 1'h1;
                  next_s.mstate = smp_pkg::SMP_M_IDLE;
               end
            end
         end
         // a lost one-hot code falls back to idle
         default:
            next_s.mstate = smp_pkg::SMP_M_IDLE;
      endcase

      // another master took the bus: stop and drop the enables
      if (s.port_en & s.master_en & (s.mode == smp_pkg::SEL_MULTI) &
         ~s.nss_s2)
      begin
         next_s.master_en = 1'h0;
         next_s.port_en = 1'h0;
         next_s.flags[smp_pkg::FLAG_MODE_FAULT_FLAG] = 1'h1;
         next_s.mstate = smp_pkg::SMP_M_IDLE;
         next_s.sck_lvl = s.cpol;
      end

      // slave: buffer moves only between transfers
      if (slave_on & s.tx_full & s.sh_empty & ~s.busy_s2)
      begin
         next_s.shreg = s.tx_hold;
         next_s.tx_full = 1'h0;
         next_s.sh_empty = 1'h0;
      end
      if (slave_on & done_evt)
      begin
         next_s.sh_empty = 1'h1;
         next_s.flags[smp_pkg::FLAG_DONE] = 1'h1;
         if (s.rx_full & ~data_rd_i)
            next_s.flags[smp_pkg::FLAG_OVRN] = 1'h1;
         else
         begin
            next_s.rx_buf = d.rx_byte;
            next_s.rx_full = 1'h1;
         end
      end
      if (!slave_on)
         next_s.sh_empty = 1'h1;

      // data writes land in the transmit buffer unless still full
      if (data_wr_i)
      begin
         if (s.tx_full)
            next_s.flags[smp_pkg::FLAG_WRITE_COLLISION_FLAG] = 1'h1;
         else
         begin
            next_s.tx_hold = data_i;
            next_s.tx_full = 1'h1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.nss_s1 <= 1'h1;
         s.nss_s2 <= 1'h1;
         s.mode <= smp_pkg::RST_SELECT_MODE;
         s.port_en <= smp_pkg::RST_PORT_ENABLE;
         s.master_en <= smp_pkg::RST_MASTER_ENABLE;
         s.cpol <= smp_pkg::RST_CLOCK_POLARITY;
         s.cpha <= smp_pkg::RST_CLOCK_PHASE;
         s.tx_hold <= smp_pkg::RST_BYTE;
         s.shreg <= smp_pkg::RST_BYTE;
         s.rx_buf <= smp_pkg::RST_BYTE;
         s.sh_empty <= 1'h1;
         s.mstate <= smp_pkg::SMP_M_IDLE;
      end
      else
         s <= next_s;
   end

   // status outputs
   assign port_enable_bit_o = s.port_en;
   assign master_enable_bit_o = s.master_en;
   assign data_o = s.rx_buf;
   assign transfer_complete_flag_o = s.flags[smp_pkg::FLAG_DONE];
   assign write_collision_flag_o = s.flags[smp_pkg::FLAG_WRITE_COLLISION_FLAG];
   assign mode_fault_flag_o = s.flags[smp_pkg::FLAG_MODE_FAULT_FLAG];
   assign receive_overrun_flag_o = s.flags[smp_pkg::FLAG_OVRN];
   assign tx_buffer_empty_o = ~s.tx_full;
   assign rx_buffer_full_o = s.rx_full;
   assign shift_empty_o = s.sh_empty;
   assign busy_o = (s.mstate == smp_pkg::SMP_M_RUN) |
      (slave_on & s.busy_s2);

   // master pins
   assign sck_o = s.sck_lvl;
   assign sck_oe_n_o = ~(s.port_en & s.master_en);
   assign mosi_o = s.shreg[7];
   assign mosi_oe_n_o = ~(s.port_en & s.master_en);

   // slave-out: bit picked by the link position, msb first
   assign miso_o = s.shreg[3'h7 - out_pos];
   assign miso_oe_n_o = ~(slave_on & (slave_sel | s.mode[1]));

   // select pin
   assign nss_o = s.mode[0];
   assign nss_oe_n_o = ~(s.port_en & s.mode[1]);
   assign nss_pin_mapped_o = (s.mode != smp_pkg::SEL_THREE_WIRE);

endmodule : smp_port
